// File: verilog/dwa_pkg.sv
// Constants, encodings and state codes for the dual wiper adjust block.
// Assumes a single 25 MHz core clock and a 24-bit serial frame from the host.
package dwa_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int unsigned FRAME_W = 24; // Bits in one frame
    localparam int unsigned CMD_MSB = 23; // Command nibble top
    localparam int unsigned CMD_LSB = 20; // Command nibble bottom
    localparam int unsigned ADR_MSB = 19; // Address nibble top
    localparam int unsigned ADR_LSB = 16; // Address nibble bottom
    localparam int unsigned DAT_MSB = 15; // Data word top
    localparam int unsigned WIPER_W = 10; // Wiper setting width
    localparam int unsigned WORD_W = 16; // Stored word width
    localparam int unsigned NVM_N = 16; // Stored words
    localparam int unsigned CNT_W = 5; // Serial edge counter width

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_NOP = 4'h0; // Back to low power
    localparam logic [3:0] CMD_RESTORE = 4'h1; // Stored to wiper, one
    localparam logic [3:0] CMD_STORE = 4'h2; // Wiper to stored word
    localparam logic [3:0] CMD_WR_NVM = 4'h3; // Data to stored word
    localparam logic [3:0] CMD_DEC6 = 4'h4; // Right shift, one
    localparam logic [3:0] CMD_DEC6_ALL = 4'h5; // Right shift, both
    localparam logic [3:0] CMD_DEC = 4'h6; // Minus one, one
    localparam logic [3:0] CMD_DEC_ALL = 4'h7; // Minus one, both
    localparam logic [3:0] CMD_REFRESH = 4'h8; // Stored to wipers, both
    localparam logic [3:0] CMD_RD_NVM = 4'h9; // Read stored word
    localparam logic [3:0] CMD_RD_WIPER = 4'ha; // Read wiper
    localparam logic [3:0] CMD_WR_WIPER = 4'hb; // Data to wiper
    localparam logic [3:0] CMD_INC6 = 4'hc; // Left shift, one
    localparam logic [3:0] CMD_INC6_ALL = 4'hd; // Left shift, both
    localparam logic [3:0] CMD_INC = 4'he; // Plus one, one
    localparam logic [3:0] CMD_INC_ALL = 4'hf; // Plus one, both

    // ------------------------------------------------------------
    // Store map and wiper values
    // ------------------------------------------------------------
    localparam logic [3:0] ADR_WIPER1 = 4'h0; // Stored channel 1
    localparam logic [3:0] ADR_WIPER2 = 4'h1; // Stored channel 2
    localparam logic [3:0] ADR_USER_FIRST = 4'h2; // First user word
    localparam logic [3:0] ADR_USER_LAST = 4'he; // Last user word
    localparam logic [3:0] ADR_TOL = 4'hf; // Tolerance word
    localparam logic [9:0] WIPER_ZERO = 10'h000; // Zero scale
    localparam logic [9:0] WIPER_ONE = 10'h001; // One step
    localparam logic [9:0] WIPER_MID = 10'h200; // Midscale
    localparam logic [9:0] WIPER_FULL = 10'h3ff; // Full scale
    localparam logic [5:0] WIPER_PAD = 6'h00; // Upper bits of a wiper word

    // ------------------------------------------------------------
    // Core states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_BOOT = 2'b01, // Copying stored settings after reset
        ST_RUN = 2'b10 // Executing frames
    } dwa_state_t;

endpackage : dwa_pkg

// File: verilog/dwa_core.sv
// Command interpreter for a dual 10-bit wiper pair and its 16-word store.
// Assumes a host on a serial port: cs_n frames, data taken on sclk rise.
module dwa_core #(
    parameter logic [9:0] WIPER_INIT = 10'h200, // Stored wiper value after reset
    parameter logic TOL_POSITIVE = 1'b1, // Tolerance sign, 1 means positive
    parameter logic [6:0] TOL_INT = 7'h00, // Tolerance integer percent
    parameter logic [7:0] TOL_FRAC = 8'h00 // Tolerance fraction percent
) (
    input wire logic clk, // Core clock, 25 MHz
    input wire logic rst_n, // Async reset, active low
    input wire logic sclk, // Serial clock from host
    input wire logic cs_n, // Frame select, active low
    input wire logic sdi, // Serial data in
    output logic sdo, // Serial data out
    input wire logic preset_n, // Preset strobe, active low
    output logic [9:0] wiper1, // Channel 1 wiper setting
    output logic [9:0] wiper2, // Channel 2 wiper setting
    output logic read_power // High while in read power state
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (dwa_pkg::FRAME_W != dwa_pkg::CMD_MSB + 1) begin : g_chk
        $error("Frame width does not match command position");
    end

    // ------------------------------------------------------------
    // State records, one per clock domain
    // ------------------------------------------------------------
    typedef struct packed {
        logic [23:0] shift; // Last 24 bits taken in
        logic [23:0] out; // Outgoing shifter
        logic [4:0] edges; // Free running edge count
    } dwa_link_t;

    typedef struct packed {
        logic [2:0] cs_s; // Chip select synchroniser
        logic [2:0] pr_s; // Preset synchroniser
        logic cs_lvl; // Filtered chip select level
        logic pr_lvl; // Filtered preset level
        dwa_pkg::dwa_state_t st; // Core state
        logic [4:0] seen; // Edge count at last frame end
        logic [23:0] last; // Last executed frame
        logic [23:0] rd; // Word for next frame out
        logic [1:0][9:0] wiper; // Live wiper settings
        logic [15:0][15:0] nvm; // Stored words
        logic rdpwr; // Read power state
    } dwa_core_t;

    dwa_link_t ln_q, ln_d;
    dwa_core_t st_q, st_d;

    // Tolerance word: sign, integer, fraction
    logic [15:0] tol_word;
    assign tol_word = {TOL_POSITIVE, TOL_INT, TOL_FRAC};

    // ------------------------------------------------------------
    // Link domain: shifter on the host clock
    // ------------------------------------------------------------
    // First edge of a frame: edge count still equals what the core saw.
    // The core count stands still while the host clock runs, so no hazard.
    logic first_edge; // Next edge is the first of the frame
    assign first_edge = (ln_q.edges == st_q.seen);

    // Shift in, count edges, and feed read data out
    always_comb begin
        ln_d = ln_q;
        ln_d.shift = {ln_q.shift[22:0], sdi};
        ln_d.edges = 5'(ln_q.edges + 5'h01);
        if (first_edge) begin
            ln_d.out = {st_q.rd[22:0], 1'b0};
        end else begin
            ln_d.out = {ln_q.out[22:0], 1'b0};
        end
    end

    // Link registers; host clock only runs inside frames
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            ln_q <= '0;
        end else begin
            ln_q <= ln_d;
        end
    end

    // Output bit: prepared word before the first edge, shifter after
    assign sdo = first_edge ? st_q.rd[23] : ln_q.out[23];

    // ------------------------------------------------------------
    // Wiper step arithmetic
    // ------------------------------------------------------------
    // Low bit of the code only picks one or both channels
    function automatic logic [9:0] step(input logic [3:0] c, input logic [9:0] w);
        logic [9:0] r;
        r = w;
        case ({c[3:1], 1'b0})
            dwa_pkg::CMD_INC: begin
                r = (w == dwa_pkg::WIPER_FULL) ? w : 10'(w + dwa_pkg::WIPER_ONE);
            end
            dwa_pkg::CMD_DEC: begin
                r = (w == dwa_pkg::WIPER_ZERO) ? w : 10'(w - dwa_pkg::WIPER_ONE);
            end
            dwa_pkg::CMD_INC6: begin
                if (w == dwa_pkg::WIPER_ZERO) begin
                    r = dwa_pkg::WIPER_ONE;
                end else if (w >= dwa_pkg::WIPER_MID) begin
                    r = dwa_pkg::WIPER_FULL;
                end else begin
                    r = {w[8:0], 1'b0};
                end
            end
            dwa_pkg::CMD_DEC6: begin
                r = {1'b0, w[9:1]};
            end
            default: begin
                r = w;
            end
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // Core domain decode
    // ------------------------------------------------------------
    logic cs_rise; // Frame end seen on the core clock
    logic pr_fall; // Preset strobe seen
    logic exec; // Execute a frame this cycle
    logic fresh; // Host clocked bits in this frame
    logic [23:0] word; // Frame being executed
    logic [3:0] cmd; // Its command
    logic [3:0] adr; // Its address
    logic ch; // Chosen channel
    logic [9:0] w_sel; // Chosen wiper now

    // Second and third stages must agree before a change counts
    assign cs_rise = (st_q.cs_s[1] == st_q.cs_s[2]) && st_q.cs_s[2] && !st_q.cs_lvl;
    assign pr_fall = (st_q.pr_s[1] == st_q.pr_s[2]) && !st_q.pr_s[2] && st_q.pr_lvl;
    assign exec = cs_rise && (st_q.st == dwa_pkg::ST_RUN);
    assign fresh = (ln_q.edges != st_q.seen); // Host link is idle here
    assign word = fresh ? ln_q.shift : st_q.last;
    assign cmd = word[dwa_pkg::CMD_MSB:dwa_pkg::CMD_LSB];
    assign adr = word[dwa_pkg::ADR_MSB:dwa_pkg::ADR_LSB];
    assign ch = adr[0];
    assign w_sel = st_q.wiper[ch];

    // ------------------------------------------------------------
    // Core next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.cs_s = {st_q.cs_s[1:0], cs_n};
        st_d.pr_s = {st_q.pr_s[1:0], preset_n};
        if (st_q.cs_s[1] == st_q.cs_s[2]) begin
            st_d.cs_lvl = st_q.cs_s[2];
        end
        if (st_q.pr_s[1] == st_q.pr_s[2]) begin
            st_d.pr_lvl = st_q.pr_s[2];
        end
        st_d.nvm[dwa_pkg::ADR_TOL] = tol_word;
        unique case (st_q.st)
            dwa_pkg::ST_BOOT: begin
                // Power-up copy of the stored settings
                st_d.wiper[0] = st_q.nvm[dwa_pkg::ADR_WIPER1][9:0];
                st_d.wiper[1] = st_q.nvm[dwa_pkg::ADR_WIPER2][9:0];
                st_d.st = dwa_pkg::ST_RUN;
            end
            dwa_pkg::ST_RUN: begin
                if (exec) begin
                    // Frame end: remember it and prepare the default echo
                    st_d.seen = ln_q.edges;
                    st_d.last = word;
                    st_d.rd = word;
                    case (cmd)
                        dwa_pkg::CMD_NOP: begin
                            st_d.rdpwr = 1'b0;
                        end
                        dwa_pkg::CMD_RESTORE: begin
                            st_d.wiper[ch] = st_q.nvm[{3'h0, ch}][9:0];
                            st_d.rdpwr = 1'b1;
                        end
                        dwa_pkg::CMD_STORE: begin
                            st_d.nvm[{3'h0, ch}] = {dwa_pkg::WIPER_PAD, w_sel};
                        end
                        dwa_pkg::CMD_WR_NVM: begin
                            // Tolerance word refuses writes
                            if (adr != dwa_pkg::ADR_TOL) begin
                                st_d.nvm[adr] = word[dwa_pkg::DAT_MSB:0];
                            end
                        end
                        dwa_pkg::CMD_REFRESH: begin
                            st_d.wiper[0] = st_q.nvm[dwa_pkg::ADR_WIPER1][9:0];
                            st_d.wiper[1] = st_q.nvm[dwa_pkg::ADR_WIPER2][9:0];
                        end
                        dwa_pkg::CMD_RD_NVM: begin
                            st_d.rd = {cmd, adr, st_q.nvm[adr]};
                        end
                        dwa_pkg::CMD_RD_WIPER: begin
                            st_d.rd = {cmd, adr, dwa_pkg::WIPER_PAD, w_sel};
                        end
                        dwa_pkg::CMD_WR_WIPER: begin
                            st_d.wiper[ch] = word[9:0];
                        end
                        dwa_pkg::CMD_INC, dwa_pkg::CMD_DEC,
                        dwa_pkg::CMD_INC6, dwa_pkg::CMD_DEC6: begin
                            st_d.wiper[ch] = step(cmd, w_sel);
                        end
                        default: begin
                            // Ganged codes: both channels in the same cycle
                            st_d.wiper[0] = step(cmd, st_q.wiper[0]);
                            st_d.wiper[1] = step(cmd, st_q.wiper[1]);
                        end
                    endcase
                end
                // Preset strobe wins over a frame ending in the same cycle
                if (pr_fall) begin
                    st_d.wiper[0] = st_q.nvm[dwa_pkg::ADR_WIPER1][9:0];
                    st_d.wiper[1] = st_q.nvm[dwa_pkg::ADR_WIPER2][9:0];
                end
            end
        endcase
    end

    // Core registers; stored words come back at reset as the defaults
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.cs_s <= 3'h7;
            st_q.pr_s <= 3'h7;
            st_q.cs_lvl <= 1'b1;
            st_q.pr_lvl <= 1'b1;
            st_q.st <= dwa_pkg::ST_BOOT;
            st_q.nvm[dwa_pkg::ADR_WIPER1] <= {dwa_pkg::WIPER_PAD, WIPER_INIT};
            st_q.nvm[dwa_pkg::ADR_WIPER2] <= {dwa_pkg::WIPER_PAD, WIPER_INIT};
        end else begin
            st_q <= st_d;
        end
    end

    assign wiper1 = st_q.wiper[0];
    assign wiper2 = st_q.wiper[1];
    assign read_power = st_q.rdpwr;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    inc_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec && !pr_fall && cmd == dwa_pkg::CMD_INC && !ch && w_sel != dwa_pkg::WIPER_FULL
        |=> wiper1 == 10'($past(wiper1) + dwa_pkg::WIPER_ONE))
        else $error("single increment missed");

    gang_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec && !pr_fall && cmd == dwa_pkg::CMD_INC_ALL
        |=> wiper1 == (($past(wiper1) == dwa_pkg::WIPER_FULL) ? dwa_pkg::WIPER_FULL
            : 10'($past(wiper1) + dwa_pkg::WIPER_ONE))
        && wiper2 == (($past(wiper2) == dwa_pkg::WIPER_FULL) ? dwa_pkg::WIPER_FULL
            : 10'($past(wiper2) + dwa_pkg::WIPER_ONE)))
        else $error("ganged increment missed");

    dec_floor_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec && !pr_fall && cmd == dwa_pkg::CMD_DEC && w_sel == dwa_pkg::WIPER_ZERO
        |=> ($past(ch) ? wiper2 : wiper1) == dwa_pkg::WIPER_ZERO)
        else $error("decrement wrapped");

    shl_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec && !pr_fall && cmd == dwa_pkg::CMD_INC6 && !ch
        && wiper1 == dwa_pkg::WIPER_ZERO |=> wiper1 == dwa_pkg::WIPER_ONE)
        else $error("left shift of zero wrong");

    shl_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec && !pr_fall && cmd[3:1] == dwa_pkg::CMD_INC6[3:1] && !ch
        && wiper1 >= dwa_pkg::WIPER_MID |=> wiper1 == dwa_pkg::WIPER_FULL)
        else $error("left shift did not saturate");

    shr_half_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec && !pr_fall && cmd == dwa_pkg::CMD_DEC6
        |=> ($past(ch) ? wiper2 : wiper1) == {1'b0, $past(w_sel[9:1])}
        && ($past(ch) ? wiper1 : wiper2) == $past(ch ? wiper1 : wiper2))
        else $error("right shift wrong");

    tol_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_q.st == dwa_pkg::ST_RUN |-> st_q.nvm[dwa_pkg::ADR_TOL] == tol_word)
        else $error("tolerance word altered");

    repeat_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec && !fresh && !pr_fall
        && st_q.last[dwa_pkg::CMD_MSB:dwa_pkg::CMD_LSB] == dwa_pkg::CMD_INC
        && !st_q.last[dwa_pkg::ADR_LSB] && wiper1 != dwa_pkg::WIPER_FULL
        |=> wiper1 == 10'($past(wiper1) + dwa_pkg::WIPER_ONE))
        else $error("bare strobe did not repeat");

    boot_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_q.st == dwa_pkg::ST_BOOT
        |=> wiper1 == st_q.nvm[dwa_pkg::ADR_WIPER1][9:0] && st_q.st == dwa_pkg::ST_RUN)
        else $error("boot copy missed");

    power_state_a: assert property (@(posedge clk) disable iff (!rst_n)
        exec && cmd == dwa_pkg::CMD_RESTORE |=> read_power ##1 (read_power || cs_rise))
        else $error("read power state not held");

endmodule : dwa_core

// File: verification/dwa_host.sv
// Host model: serial master that frames 24-bit words towards the core.
// Assumes the bench calls its tasks; the serial clock runs only inside frames.
module dwa_host (
    input wire logic clk, // Core clock, used to pace chip select
    output logic sclk, // Serial clock, 6 ns period in frames
    output logic cs_n, // Frame select, active low
    output logic sdi, // Serial data to the core
    input wire logic sdo // Serial data from the core
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    // Link clock stands still and select is high between frames
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame transfer
    // ------------------------------------------------------------
    // Full 24-bit word, MSB first; returns what the core shifted out
    task automatic send(input logic [23:0] w, output logic [23:0] r);
        int i;
        @(negedge clk);
        cs_n = 1'b0;
        for (i = 23; i >= 0; i--) begin
            sdi = w[i];
            #3;
            r[i] = sdo; // Bit is settled before the rise that moves it on
            sclk = 1'b1;
            #3;
            sclk = 1'b0;
        end
        sdi = ~w[0]; // Released line shows no stale value
        @(negedge clk);
        cs_n = 1'b1;
        repeat (7) @(negedge clk); // Covers execute latency and the frame gap
    endtask

    // Select pulse with no clock and no data repeats the last command
    task automatic strobe();
        @(negedge clk);
        cs_n = 1'b0;
        repeat (6) @(negedge clk);
        cs_n = 1'b1;
        repeat (7) @(negedge clk);
    endtask
endmodule // dwa_host

// File: verification/dual_wiper_adjust_and_user_nvm_bench.sv
// Bench for the wiper command interpreter: frames sent through the host model.
// Assumes the core's default parameters and a 25 MHz core clock.
module dual_wiper_adjust_and_user_nvm_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk, rst_n, sclk, cs_n, sdi, sdo, preset_n, read_power; // Core pins
    logic [9:0] wiper1, wiper2; // Wiper outputs
    logic [23:0] rx; // Word shifted out during the last frame
    logic [9:0] e; // Expected wiper value
    int fail_count = 0;
    int checks_done = 0;
    logic [3:0] gcmd [4] = '{4'hf, 4'h7, 4'hd, 4'h5}; // Ganged codes
    logic [9:0] ge1 [4] = '{10'h3ff, 10'h3fe, 10'h3ff, 10'h1ff};
    logic [9:0] ge2 [4] = '{10'h001, 10'h000, 10'h001, 10'h000};
    logic [3:0] radr [4] = '{4'h2, 4'he, 4'hf, 4'h1}; // Store addresses read back
    logic [15:0] rexp [4] = '{16'h1234, 16'hbeef, {1'b1, 7'h00, 8'h00}, 16'h0200};

    // ------------------------------------------------------------
    // Clock and instances
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    dwa_core dwa_core_i (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo), .preset_n(preset_n), .wiper1(wiper1), .wiper2(wiper2),
        .read_power(read_power));
    dwa_host dwa_host_i (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Compare and count; four-state equality so an unknown never matches
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic op(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
        dwa_host_i.send({c, a, d}, rx);
    endtask

    // Left shift with the zero and midscale corrections
    function automatic logic [9:0] shl(input logic [9:0] v);
        if (v == 10'h000) return 10'h001;
        if (v >= 10'h200) return 10'h3ff;
        return {v[8:0], 1'b0};
    endfunction

    task automatic close_out();
        if (fail_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard, far beyond the length of the sequence
    initial begin
        #200000;
        fail_count++;
        $display("[FAIL] %0t timeout", $time);
        close_out();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        preset_n = 1'b1;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk(16'(wiper1), 16'h0200);
        chk(16'(wiper2), 16'h0200);
        // Left shift climb from zero, junk in the data bytes
        op(dwa_pkg::CMD_WR_WIPER, 4'h0, 16'h0000);
        e = 10'h000;
        for (int k = 0; k < 13; k++) begin
            op(dwa_pkg::CMD_INC6, 4'h0, 16'ha5a5);
            e = shl(e);
            chk(16'(wiper1), 16'(e));
        end
        // Right shift fall to zero and beyond on channel 2
        op(dwa_pkg::CMD_WR_WIPER, 4'h1, 16'h03ff);
        e = 10'h3ff;
        for (int k = 0; k < 12; k++) begin
            op(dwa_pkg::CMD_DEC6, 4'h1, 16'hffff);
            e = e >> 1;
            chk(16'(wiper2), 16'(e));
        end
        // Linear steps at the ends of the range
        op(dwa_pkg::CMD_WR_WIPER, 4'h0, 16'h03fe);
        op(dwa_pkg::CMD_INC, 4'h0, 16'h5555);
        chk(16'(wiper1), 16'h03ff);
        op(dwa_pkg::CMD_INC, 4'h0, 16'h0000);
        chk(16'(wiper1), 16'h03ff);
        op(dwa_pkg::CMD_WR_WIPER, 4'h1, 16'h0001);
        op(dwa_pkg::CMD_DEC, 4'h1, 16'h0000);
        chk(16'(wiper2), 16'h0000);
        dwa_host_i.strobe();
        chk(16'(wiper2), 16'h0000);
        // Bare strobe repeats an increment
        op(dwa_pkg::CMD_WR_WIPER, 4'h0, 16'h0100);
        op(dwa_pkg::CMD_INC, 4'h0, 16'h0000);
        dwa_host_i.strobe();
        chk(16'(wiper1), 16'h0102);
        // Ganged codes on opposite extremes
        op(dwa_pkg::CMD_WR_WIPER, 4'h0, 16'h03ff);
        op(dwa_pkg::CMD_WR_WIPER, 4'h1, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            op(gcmd[k], 4'h0, 16'h0000);
            chk(16'(wiper1), 16'(ge1[k]));
            chk(16'(wiper2), 16'(ge2[k]));
        end
        // Store map: user words, read-only tolerance, stored wiper
        op(dwa_pkg::CMD_WR_NVM, dwa_pkg::ADR_USER_FIRST, 16'h1234);
        op(dwa_pkg::CMD_WR_NVM, dwa_pkg::ADR_USER_LAST, 16'hbeef);
        op(dwa_pkg::CMD_WR_NVM, dwa_pkg::ADR_TOL, 16'h7777);
        for (int k = 0; k < 4; k++) begin
            op(dwa_pkg::CMD_RD_NVM, radr[k], 16'h0000);
            op(dwa_pkg::CMD_NOP, 4'h0, 16'h0000);
            chk(rx[15:0], rexp[k]);
        end
        // Restore, power state, refresh and preset
        op(dwa_pkg::CMD_WR_NVM, dwa_pkg::ADR_WIPER1, 16'h0155);
        op(dwa_pkg::CMD_RESTORE, dwa_pkg::ADR_WIPER1, 16'h0000);
        chk(16'(wiper1), 16'h0155);
        chk(16'(read_power), 16'h0001);
        op(dwa_pkg::CMD_NOP, 4'h0, 16'h0000);
        chk(16'(read_power), 16'h0000);
        op(dwa_pkg::CMD_WR_NVM, dwa_pkg::ADR_WIPER2, 16'h00aa);
        op(dwa_pkg::CMD_WR_WIPER, 4'h0, 16'h0001);
        op(dwa_pkg::CMD_REFRESH, 4'h0, 16'h0000);
        chk(16'(wiper1), 16'h0155);
        chk(16'(wiper2), 16'h00aa);
        op(dwa_pkg::CMD_WR_WIPER, 4'h0, 16'h0000);
        op(dwa_pkg::CMD_WR_WIPER, 4'h1, 16'h0000);
        @(negedge clk);
        preset_n = 1'b0;
        repeat (6) @(negedge clk);
        preset_n = 1'b1;
        repeat (2) @(negedge clk);
        chk(16'(wiper1), 16'h0155);
        chk(16'(wiper2), 16'h00aa);
        // Store a wiper, read it and the other wiper back, then the plain echo
        op(dwa_pkg::CMD_WR_WIPER, 4'h1, 16'h0123);
        op(dwa_pkg::CMD_STORE, 4'h1, 16'h0000);
        op(dwa_pkg::CMD_RD_NVM, dwa_pkg::ADR_WIPER2, 16'h0000);
        op(dwa_pkg::CMD_RD_WIPER, 4'h0, 16'h0000);
        chk(rx[15:0], 16'h0123);
        op(dwa_pkg::CMD_NOP, 4'h3, 16'hc3c3);
        chk(rx[15:0], 16'h0155);
        op(dwa_pkg::CMD_NOP, 4'h0, 16'h0000);
        chk(rx[15:0], 16'hc3c3);
        chk(16'(rx[23:16]), 16'h0003);
        // Second reset in mid-run: wipers clear, then the boot copy returns
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk(16'(wiper1), 16'h0000);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk(16'(wiper2), 16'h0200);
        op(dwa_pkg::CMD_INC, 4'h0, 16'h0000);
        chk(16'(wiper1), 16'h0201);
        close_out();
    end
endmodule // dual_wiper_adjust_and_user_nvm_bench
